/* core/cco_seq.sv */
// main-processor sequencer for coprocessor conditional instructions
// assumes an apb master, an instruction fetch port, a coprocessor
// interface port, a service unit and an effective-address store unit
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "cco_consts.svh"

module cco_seq
    import cco_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // instruction fetch
    output logic             fetch_req,
    output logic      [31:0] fetch_addr,
    input  wire logic        fetch_ack,
    input  wire logic [15:0] fetch_data,
    // coprocessor interface registers
    output cco_cp_req_s      cp_out,
    output logic      [2:0]  coprocessor_identifier,
    input  wire logic        cp_ack,
    input  wire logic [15:0] cp_rdata,
    // response primitive service
    output logic             svc_req,
    output logic      [15:0] svc_word,
    input  wire logic        svc_ack,
    // destination byte store
    output logic             st_req,
    output logic      [5:0]  st_mode,
    output logic      [31:0] st_ext_ptr,
    output logic      [7:0]  st_data,
    input  wire logic        st_ack,
    // exception starts
    output logic             excp_trap,
    output logic             excp_proto
);
    function automatic logic [31:0] words(input logic [2:0] n);
        words = {28'h0, n, 1'b0};
    endfunction

    cco_state_e  st_q, st_d;
    cco_status_s stat_q;
    logic [15:0] op_q, sel_q;
    logic [6:0]  ctrl_q;
    logic [31:0] pc_q, scan_q, next_q;
    logic [31:0] dreg_q [8];
    logic        cond_q, trap_p_q, proto_p_q;

    // opword decode; decrement and trap patterns win over set-byte
    wire        fline    = op_q[15:12] == `CCO_FLINE;
    wire        is_dbcc  = fline && op_q[8:3] == `CCO_PAT_DBCC;
    wire        is_trap  = fline && op_q[8:3] == `CCO_PAT_TRAP;
    wire        is_scc   = fline && op_q[8:6] == `CCO_PAT_SCC
                           && !is_dbcc && !is_trap;
    wire        opm_ok   = op_q[2:0] == `CCO_OPM_ONE
                           || op_q[2:0] == `CCO_OPM_TWO
                           || op_q[2:0] == `CCO_OPM_ZERO;
    wire [2:0]  opm_cnt  = op_q[2:0] == `CCO_OPM_ONE ? 3'd1 :
                           op_q[2:0] == `CCO_OPM_TWO ? 3'd2 : 3'd0;
    wire        legal    = is_scc || is_dbcc || (is_trap && opm_ok);
    wire [2:0]  cpx_cnt  = ctrl_q[`CCO_CTRL_CPX_LO +: 3];
    // more than five address words is clipped, the limit of any mode
    wire [2:0]  eax_raw  = ctrl_q[`CCO_CTRL_EAX_LO +: 3];
    wire [2:0]  eax_cnt  = eax_raw > 3'd5 ? 3'd5 : eax_raw;

    // apb decode; zero wait states
    wire        acc      = psel && penable;
    wire        wr_en    = acc && pwrite;
    wire        is_dreg  = paddr[7:5] == 3'b001 && paddr[1:0] == 2'b00;
    wire [2:0]  dreg_ix  = paddr[4:2];
    wire        hit      = paddr == `CCO_OFS_CTRL
                           || paddr == `CCO_OFS_OPWORD
                           || paddr == `CCO_OFS_PC
                           || paddr == `CCO_OFS_STATUS
                           || paddr == `CCO_OFS_NEXTPC || is_dreg;
    wire        start    = wr_en && paddr == `CCO_OFS_CTRL
                           && pwdata[`CCO_CTRL_START] && st_q == ST_IDLE;

    // response decode
    wire        rsp_ca   = cp_rdata[`CCO_RSP_CA];
    wire        rsp_null = cp_rdata[`CCO_RSP_KIND_HI:`CCO_RSP_KIND_LO]
                           == `CCO_RSP_NULL;
    wire        rsp_fin  = rsp_null && !rsp_ca;
    wire        rsp_bad  = !rsp_null && !rsp_ca;
    wire        rsp_tru  = cp_rdata[`CCO_RSP_TRUE];
    wire        rsp_got  = st_q == ST_RRESP && cp_ack;

    // loop counter: low word only
    wire [31:0] cnt_old  = dreg_q[op_q[2:0]];
    wire [15:0] cnt_new  = cnt_old[15:0] - 16'h1;
    wire        cnt_end  = cnt_new == `CCO_CNT_END;
    wire [31:0] disp_x   = {{16{fetch_data[15]}}, fetch_data};
    wire        disp_got = st_q == ST_FDISP && fetch_ack;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:  if (start && legal) st_d = ST_FSEL;
            ST_FSEL:  if (fetch_ack) st_d = ST_WCOND;
            ST_WCOND: if (cp_ack) st_d = ST_RRESP;
            ST_RRESP: begin
                if (cp_ack) begin
                    if (rsp_fin && is_scc)
                        st_d = ST_STORE;
                    else if (rsp_fin && is_dbcc && !rsp_tru)
                        st_d = ST_FDISP;
                    else if (rsp_fin || rsp_bad)
                        st_d = ST_FIN;
                    else if (!rsp_null)
                        st_d = ST_SVC;
                end
            end
            ST_SVC:   if (svc_ack) st_d = ST_RRESP;
            ST_FDISP: if (fetch_ack) st_d = ST_FIN;
            ST_STORE: if (st_ack) st_d = ST_FIN;
            ST_FIN:   st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst)
            st_q <= ST_IDLE;
        else
            st_q <= st_d;
    end

    // apb-held configuration and instruction words
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_q <= `CCO_CTRL_RST;
            op_q   <= 16'h0;
            pc_q   <= 32'h0;
        end else if (wr_en && st_q == ST_IDLE) begin
            if (paddr == `CCO_OFS_CTRL)
                ctrl_q <= {pwdata[6:1], 1'b0};
            if (paddr == `CCO_OFS_OPWORD)
                op_q <= pwdata[15:0];
            if (paddr == `CCO_OFS_PC)
                pc_q <= pwdata;
        end
    end

    // the sequencer owns the counter only in ST_FDISP, so a bus write in the cycle
    // the displacement arrives is dropped rather than racing the decrement
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 8; i++)
                dreg_q[i] <= 32'h0;
        end else if (disp_got && !cond_q) begin
            dreg_q[op_q[2:0]] <= {cnt_old[31:16], cnt_new};
        end else if (wr_en && is_dreg) begin
            dreg_q[dreg_ix] <= pwdata;
        end
    end

    // scan pointer walk
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            scan_q <= 32'h0;
            sel_q  <= 16'h0;
        end else if (start) begin
            scan_q <= pc_q + 32'h2;
        end else if (st_q == ST_FSEL && fetch_ack) begin
            sel_q  <= fetch_data;
            scan_q <= scan_q + 32'h2 + words(cpx_cnt);
        end
    end

    // result, next address and exception pulses
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cond_q    <= 1'b0;
            next_q    <= 32'h0;
            stat_q    <= '0;
            trap_p_q  <= 1'b0;
            proto_p_q <= 1'b0;
        end else begin
            trap_p_q  <= 1'b0;
            proto_p_q <= 1'b0;
            if (start) begin
                stat_q      <= '0;
                stat_q.busy <= legal;
                stat_q.done <= !legal;
                stat_q.illegal <= !legal;
            end
            if (rsp_got && rsp_fin) begin
                cond_q      <= rsp_tru;
                stat_q.cond <= rsp_tru;
                if (is_dbcc && rsp_tru)
                    next_q <= scan_q + 32'h2;
                if (is_trap) begin
                    next_q <= scan_q + words(opm_cnt);
                    stat_q.trap <= rsp_tru;
                    trap_p_q    <= rsp_tru;
                end
            end
            if (rsp_got && rsp_bad) begin
                stat_q.proto <= 1'b1;
                proto_p_q    <= 1'b1;
            end
            if (disp_got) begin
                stat_q.branch <= !cnt_end;
                next_q <= cnt_end ? scan_q + 32'h2
                                  : scan_q + disp_x;
            end
            if (st_q == ST_STORE && st_ack)
                next_q <= scan_q + words(eax_cnt);
            if (st_q == ST_FIN) begin
                stat_q.busy <= 1'b0;
                stat_q.done <= 1'b1;
            end
        end
    end

    // apb read path
    always_ff @(posedge sys_clk) begin
        if (!nrst)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite) begin
            if (paddr == `CCO_OFS_CTRL)
                prdata <= {25'h0, ctrl_q};
            else if (paddr == `CCO_OFS_OPWORD)
                prdata <= {16'h0, op_q};
            else if (paddr == `CCO_OFS_PC)
                prdata <= pc_q;
            else if (paddr == `CCO_OFS_STATUS)
                prdata <= {25'h0, stat_q};
            else if (paddr == `CCO_OFS_NEXTPC)
                prdata <= next_q;
            else if (is_dreg)
                prdata <= dreg_q[dreg_ix];
            else
                prdata <= 32'h0;
        end
    end

    assign pready     = 1'b1;
    assign pslverr    = acc && !hit;
    assign fetch_req  = st_q == ST_FSEL || st_q == ST_FDISP;
    assign fetch_addr = st_q == ST_FSEL ? pc_q + 32'h2 : scan_q;
    assign cp_out.req   = st_q == ST_WCOND || st_q == ST_RRESP;
    assign cp_out.wr    = st_q == ST_WCOND;
    assign cp_out.resp  = st_q == ST_RRESP;
    assign cp_out.wdata = sel_q;
    assign coprocessor_identifier = op_q[11:9];
    assign svc_req    = st_q == ST_SVC;
    assign svc_word   = cp_rdata;
    assign st_req     = st_q == ST_STORE;
    assign st_mode    = op_q[5:0];
    assign st_ext_ptr = scan_q;
    assign st_data    = cond_q ? `CCO_BYTE_TRUE : `CCO_BYTE_FALSE;
    assign excp_trap  = trap_p_q;
    assign excp_proto = proto_p_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_sel_fetch_addr: assert property (start && legal |=>
        fetch_req && fetch_addr == $past(pc_q) + 32'h2)
        else $error("selector address");
    a_cond_then_resp: assert property (st_q == ST_WCOND && cp_ack |=>
        cp_out.req && cp_out.resp && !cp_out.wr) else $error("no read");
    a_scc_true_byte: assert property (rsp_got && rsp_fin && is_scc
        && rsp_tru |=> st_req && st_data == 8'hff) else $error("true byte");
    a_scc_false_byte: assert property (rsp_got && rsp_fin && is_scc
        && !rsp_tru |=> st_req && st_data == 8'h00)
        else $error("false byte");
    a_dbcc_true_skip: assert property (rsp_got && rsp_fin && rsp_tru
        && is_dbcc |=> st_q == ST_FIN ##1 $stable(dreg_q[op_q[2:0]]))
        else $error("counter touched");
    a_dbcc_branch_tgt: assert property (disp_got && !cnt_end |=>
        next_q == $past(scan_q) + {{16{$past(fetch_data[15])}},
        $past(fetch_data)} && stat_q.branch) else $error("target");
    a_proto_fault: assert property (rsp_got && rsp_bad |=>
        excp_proto ##1 !excp_proto) else $error("protocol fault");
    a_trap_start: assert property (rsp_got && rsp_fin && is_trap
        |=> excp_trap == $past(rsp_tru)) else $error("trap start");
    a_bad_opmode: assert property (start && is_trap && !opm_ok |=>
        stat_q.illegal && st_q == ST_IDLE) else $error("opmode");
endmodule

/* include/cco_consts.svh */
// constants for the coprocessor conditional-instruction sequencer
// assumes a 10 MHz sys_clk and a 16-bit instruction word stream
`ifndef CCO_CONSTS_SVH
`define CCO_CONSTS_SVH
`define CCO_OFS_CTRL    8'h00
`define CCO_OFS_OPWORD  8'h04
`define CCO_OFS_PC      8'h08
`define CCO_OFS_STATUS  8'h0c
`define CCO_OFS_NEXTPC  8'h10
`define CCO_OFS_DREG    8'h20
`define CCO_CTRL_START  0
`define CCO_CTRL_CPX_LO 1
`define CCO_CTRL_EAX_LO 4
`define CCO_CTRL_RST    7'h00
`define CCO_FLINE       4'hf
`define CCO_PAT_SCC     3'b001
`define CCO_PAT_DBCC    6'b001001
`define CCO_PAT_TRAP    6'b001111
`define CCO_OPM_ONE     3'b010
`define CCO_OPM_TWO     3'b011
`define CCO_OPM_ZERO    3'b100
`define CCO_RSP_CA      15
`define CCO_RSP_KIND_HI 14
`define CCO_RSP_KIND_LO 13
`define CCO_RSP_NULL    2'b00
`define CCO_RSP_TRUE    0
`define CCO_BYTE_TRUE   8'hff
`define CCO_BYTE_FALSE  8'h00
`define CCO_CNT_END     16'hffff
`endif

/* include/cco_pkg.sv */
// types for the coprocessor conditional-instruction sequencer
// assumes cco_consts.svh sits on the include path
package cco_pkg;
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_FSEL  = 8'h02,
        ST_WCOND = 8'h04,
        ST_RRESP = 8'h08,
        ST_SVC   = 8'h10,
        ST_FDISP = 8'h20,
        ST_STORE = 8'h40,
        ST_FIN   = 8'h80
    } cco_state_e;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        resp;
        logic [15:0] wdata;
    } cco_cp_req_s;
    typedef struct packed {
        logic illegal;
        logic proto;
        logic trap;
        logic branch;
        logic cond;
        logic done;
        logic busy;
    } cco_status_s;
endpackage

/* sim/cco_partner.sv */
// far-side model: coprocessor, instruction memory, service and store units
// assumes the sequencer keeps one request outstanding at a time on sys_clk
`timescale 1ns/1ns
module cco_partner
    import cco_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // scenario settings
    input  wire logic        slow,
    input  wire logic [15:0] rsp_a,
    input  wire logic [15:0] rsp_b,
    input  wire logic [31:0] sel_addr,
    input  wire logic [15:0] sel_word,
    input  wire logic [15:0] disp_word,
    // coprocessor port
    input  wire cco_cp_req_s cp_out,
    output logic             cp_ack,
    output logic      [15:0] cp_rdata,
    // fetch, service and store ports
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ack,
    output logic      [15:0] fetch_data,
    input  wire logic        svc_req,
    output logic             svc_ack,
    input  wire logic        st_req,
    input  wire logic [7:0]  st_data,
    output logic             st_ack,
    // observations
    output logic      [15:0] wr_word,
    output logic      [7:0]  n_rd,
    output logic      [7:0]  n_svc,
    output logic      [7:0]  st_byte
);
    logic [2:0] cnt;
    logic       any_req;
    logic       acking;
    logic       go;
    assign any_req = cp_out.req | fetch_req | svc_req | st_req;
    assign acking  = cp_ack | fetch_ack | svc_ack | st_ack;
    // slow mode holds each answer back three cycles
    assign go = any_req & ~acking & (cnt >= (slow ? 3'h3 : 3'h0));
    always @(posedge sys_clk) begin
        cnt <= (!nrst || !any_req || go || acking) ? 3'h0 : cnt + 3'h1;
        cp_ack <= nrst & go & cp_out.req;
        fetch_ack <= nrst & go & fetch_req;
        svc_ack <= nrst & go & svc_req;
        st_ack <= nrst & go & st_req;
        if (go && cp_out.req && !cp_out.wr) begin
            cp_rdata <= (n_rd == 8'h00) ? rsp_a : rsp_b;
            n_rd <= n_rd + 8'h01;
        end else if (!svc_req && !cp_ack)
            cp_rdata <= ~cp_rdata; // released bus is inverted every cycle except while svc_req or cp_ack is high, instead of holding its last word
        if (go && cp_out.req && cp_out.wr) begin
            wr_word <= cp_out.wdata;
            n_rd <= 8'h00;
            n_svc <= 8'h00;
        end
        if (go && svc_req)
            n_svc <= n_svc + 8'h01;
        if (go && st_req)
            st_byte <= st_data;
        if (go && fetch_req)
            fetch_data <= (fetch_addr == sel_addr) ? sel_word : disp_word;
        else if (!fetch_ack)
            fetch_data <= ~fetch_data;
        if (!nrst) begin
            cp_rdata <= 16'h0;
            fetch_data <= 16'h0;
            wr_word <= 16'h0;
            n_rd <= 8'h00;
            n_svc <= 8'h00;
            st_byte <= 8'h00;
        end
    end
endmodule

/* sim/cco_seq_bench.sv */
// self-checking bench for the conditional-instruction sequencer
// assumes cco_partner answers every port on the far side
`timescale 1ns/1ns
module cco_seq_bench
    import cco_pkg::*;
;
    logic        sys_clk = 1'h0;
    logic        nrst = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, fetch_addr, st_ext_ptr, rd;
    logic        pready, pslverr, err, fetch_req, fetch_ack, cp_ack;
    logic        svc_req, svc_ack, st_req, st_ack, excp_trap, excp_proto;
    logic [15:0] fetch_data, cp_rdata, svc_word, wr_word;
    cco_cp_req_s cp_out;
    logic [2:0]  coprocessor_identifier, m;
    logic [5:0]  st_mode;
    logic [7:0]  st_data, st_byte, n_rd, n_svc;
    logic        slow = 1'h0;
    logic [15:0] rsp_a = 16'h0, rsp_b = 16'h0, sel_word = 16'h0;
    logic [15:0] disp_word = 16'h0, svc_seen;
    logic [31:0] sel_addr = 32'h102;
    int          mismatches = 0, total_checks = 0, n_trap = 0, n_proto = 0;
    int          i;

    cco_seq uut (
        .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fetch_req, .fetch_addr, .fetch_ack,
        .fetch_data, .cp_out, .coprocessor_identifier, .cp_ack, .cp_rdata,
        .svc_req, .svc_word, .svc_ack, .st_req, .st_mode, .st_ext_ptr,
        .st_data, .st_ack, .excp_trap, .excp_proto
    );
    cco_partner far (
        .sys_clk, .nrst, .slow, .rsp_a, .rsp_b, .sel_addr, .sel_word,
        .disp_word, .cp_out, .cp_ack, .cp_rdata, .fetch_req, .fetch_addr,
        .fetch_ack, .fetch_data, .svc_req, .svc_ack, .st_req, .st_data,
        .st_ack, .wr_word, .n_rd, .n_svc, .st_byte
    );

    always #50 sys_clk = ~sys_clk;
    // pulse widths count too: a two-cycle pulse shows up as two
    always @(posedge sys_clk) begin
        if (excp_trap === 1'h1) n_trap++;
        if (excp_proto === 1'h1) n_proto++;
        if (svc_req === 1'h1) svc_seen <= svc_word;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 20) begin
            mismatches++;
            finish_test();
        end
    endtask

    // loads an operation word, starts it and waits for busy to fall
    task run(input logic [15:0] op, input logic [6:0] ctl,
             input logic [31:0] st);
        int n;
        apb(1'h1, 8'h04, {16'h0, op});
        apb(1'h1, 8'h00, {25'h0, ctl});
        for (n = 0; n < 100; n++) begin
            apb(1'h0, 8'h0c, 32'h0);
            if (rd[0] === 1'h0) break;
        end
        if (n == 100) begin
            mismatches++;
            finish_test();
        end
        chk(rd, st);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'h1;
        apb(1'h0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h44, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'h1, 8'h08, 32'h100);
        sel_word <= 16'h0007;
        rsp_a <= 16'ha000;
        rsp_b <= 16'h0001;
        run(16'hf255, 7'h35, 32'h6);
        chk({16'h0, wr_word}, 32'h7);
        chk({16'h0, n_rd, n_svc}, 32'h0201);
        chk({16'h0, svc_seen}, 32'ha000);
        chk({13'h0, coprocessor_identifier, st_byte, 2'h0, st_mode},
            32'h0001_ff15);
        chk(st_ext_ptr, 32'h108);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h10e);
        slow <= 1'h1;
        rsp_a <= 16'h8000;
        rsp_b <= 16'h0000;
        run(16'hf255, 7'h01, 32'h2);
        chk({16'h0, st_byte, n_rd}, 32'h2);
        slow <= 1'h0;
        rsp_a <= 16'h0000;
        disp_word <= 16'hfff0;
        apb(1'h1, 8'h2c, 32'h0001_0000);
        run(16'hf24b, 7'h01, 32'h2);
        apb(1'h0, 8'h2c, 32'h0);
        chk(rd, 32'h0001_ffff);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h106);
        apb(1'h1, 8'h2c, 32'h5);
        run(16'hf24b, 7'h03, 32'ha);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'hf6);
        rsp_a <= 16'h0001;
        run(16'hf24b, 7'h01, 32'h6);
        apb(1'h0, 8'h2c, 32'h0);
        chk(rd, 32'h4);
        for (i = 0; i < 3; i++) begin
            m = 3'(i + 2);
            run({13'h1e4f, m}, 7'h01, 32'h16);
            apb(1'h0, 8'h10, 32'h0);
            chk(rd, 32'(32'h104 + 2 * ((i + 1) % 3)));
        end
        chk(n_trap, 3);
        rsp_a <= 16'h0000;
        run(16'hf27a, 7'h01, 32'h2);
        chk(n_trap, 3);
        for (i = 0; i < 8; i++)
            if (i < 2 || i > 4)
                run({13'h1e4f, 3'(i)}, 7'h01, 32'h42);
        rsp_a <= 16'h2000;
        run(16'hf255, 7'h01, 32'h22);
        chk(n_proto, 1);
        finish_test();
    end
endmodule
